// file: include/cms_params.svh
/*
 * Offsets, field positions, reset values and sequencer counts of the contact monitor.
 * Assumes a CPU data space with 8-bit addresses and 8-bit data.
 */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

`define CMS_OFS_BIAS_CTRL 8'hE0
`define CMS_OFS_LIVE_STATUS 8'hE1
`define CMS_OFS_IRQ_CTRL 8'hE8
`define CMS_OFS_COMPARE 8'hE9

`define CMS_IRQ_EN_BIT 7
`define CMS_IRQ_IF_BIT 6

`define CMS_RST_BIAS_CTRL 7'h00
`define CMS_RST_COMPARE 7'h00
`define CMS_RST_SAMPLE 7'h00

`define CMS_CHANNELS 7
`define CMS_SLOT_BITS 9
`define CMS_SLOT_US 30
`define CMS_STROBE_US 15

`endif

// file: include/cms_pkg.sv
/*
 * Types of the contact monitor.
 * Assumes cms_params.svh is on the include path.
 */
package cms_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cms_bus_req_t;
endpackage

// file: verilog/cms_monitor.sv
/*
 * Contact monitor: strobed sensing of seven contacts, compare logic and interrupt flag.
 * Assumes i_standby_clock is the free-running standby oscillator, asynchronous to i_clk,
 * and that i_contact_comp carries the per-contact current comparators, also asynchronous.
 */
// Functional notes
// - Strobe decoder, seven identical sensing channels, and shared interrupt logic.
// - All strobe timing comes from the standby clock, not the CPU clock.
// - Sensing continues while the CPU is stopped; standby clock keeps running.
// - Only one channel is strobed at a time.
// - Each channel is strobed once per 512-slot cycle of 15.36 ms.
// - Activation window lasts exactly one standby clock period.
// - Comparator is sampled half a standby period after activation.
// - Strobe latches comparator result into the channel's sample bit.
// - Sample differing from expected bit raises that channel's request.
// - Permanent-bias bit biases the contact continuously; live level readable.
// - ORed requests set shared flag; set beats software clear.
`include "cms_params.svh"

module cms_monitor #(
    parameter int NCH = `CMS_CHANNELS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_standby_clock,
    input wire logic [NCH-1:0] i_contact_comp,
    input wire cms_pkg::cms_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    output logic [NCH-1:0] o_contact_bias,
    output logic o_irq
);
    import cms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [2:0] sb_sync_q;
    logic sb_lvl_q, sb_lvl_d;
    logic [NCH-1:0] cmp1_q, cmp2_q, cmp3_q, live_q, live_d;
    logic sb_rise, sb_fall;

    always_ff @(posedge i_clk) begin
        sb_sync_q <= {sb_sync_q[1:0], i_standby_clock};
        cmp1_q <= i_contact_comp;
        cmp2_q <= cmp1_q;
        cmp3_q <= cmp2_q;
    end

    // Standby level taken once second and third stages agree
    always_comb begin
        sb_lvl_d = (sb_sync_q[1] == sb_sync_q[2]) ? sb_sync_q[2] : sb_lvl_q;
    end

    assign sb_rise = sb_lvl_d & ~sb_lvl_q;
    assign sb_fall = ~sb_lvl_d & sb_lvl_q;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_live
            always_comb begin
                live_d[g] = (cmp2_q[g] == cmp3_q[g]) ? cmp3_q[g] : live_q[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            // Follow the pin level so no false edge follows reset
            sb_lvl_q <= sb_sync_q[2];
            live_q <= '0;
        end else begin
            sb_lvl_q <= sb_lvl_d;
            live_q <= live_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decoder
    logic [`CMS_SLOT_BITS-1:0] slot_q, slot_d;
    logic [NCH-1:0] strobe_sel, sample_q, sample_d, bias_q, bias_d;
    logic [NCH-1:0] bias_ctrl_q, bias_ctrl_d;

    function automatic logic [NCH-1:0] slot_decode(input logic [`CMS_SLOT_BITS-1:0] s);
        logic [NCH-1:0] r;
        r = '0;
        if (s < NCH) begin
            r[s[2:0]] = 1'b1;
        end
        return r;
    endfunction

    assign strobe_sel = slot_decode(slot_q);

    always_comb begin
        slot_d = slot_q;
        if (sb_rise) begin
            slot_d = slot_q + 1'b1;
        end
        sample_d = sample_q;
        if (sb_fall) begin
            sample_d = (sample_q & ~strobe_sel) | (live_q & strobe_sel);
        end
        bias_d = slot_decode(slot_d) | bias_ctrl_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            slot_q <= '0;
            sample_q <= `CMS_RST_SAMPLE;
            bias_q <= '0;
        end else begin
            slot_q <= slot_d;
            sample_q <= sample_d;
            bias_q <= bias_d;
        end
    end

    assign o_contact_bias = bias_q;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and interrupt flag
    logic [NCH-1:0] cmp_val_q, cmp_val_d, chan_req;
    logic en_q, en_d, if_q, if_d, irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic wr_bias, wr_irq, wr_cmp;

    assign chan_req = sample_q ^ cmp_val_q;
    assign wr_bias = i_bus.wr && (i_bus.addr == `CMS_OFS_BIAS_CTRL);
    assign wr_irq = i_bus.wr && (i_bus.addr == `CMS_OFS_IRQ_CTRL);
    assign wr_cmp = i_bus.wr && (i_bus.addr == `CMS_OFS_COMPARE);

    always_comb begin
        bias_ctrl_d = wr_bias ? i_bus.wdata[NCH-1:0] : bias_ctrl_q;
        cmp_val_d = wr_cmp ? i_bus.wdata[NCH-1:0] : cmp_val_q;
        en_d = wr_irq ? i_bus.wdata[`CMS_IRQ_EN_BIT] : en_q;
        if_d = wr_irq ? i_bus.wdata[`CMS_IRQ_IF_BIT] : if_q;
        if (|chan_req) begin
            if_d = 1'b1;
        end
        irq_d = if_d & en_d;
        rdata_d = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `CMS_OFS_BIAS_CTRL: rdata_d = {1'b0, bias_ctrl_q};
                `CMS_OFS_LIVE_STATUS: rdata_d = {1'b0, live_q};
                `CMS_OFS_IRQ_CTRL: rdata_d = {en_q, if_q, 6'h00};
                `CMS_OFS_COMPARE: rdata_d = {1'b0, cmp_val_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bias_ctrl_q <= `CMS_RST_BIAS_CTRL;
            cmp_val_q <= `CMS_RST_COMPARE;
            en_q <= 1'b0;
            if_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            bias_ctrl_q <= bias_ctrl_d;
            cmp_val_q <= cmp_val_d;
            en_q <= en_d;
            if_q <= if_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_slot_step;
        sb_rise ##1 1'b1;
    endsequence

    sequence s_last_slot;
        sb_rise && (slot_q == '1);
    endsequence

    sequence s_mid_strobe;
        sb_fall && (slot_q < NCH);
    endsequence

    a_one_strobe: assert property ($onehot0(o_contact_bias & ~$past(bias_ctrl_q)))
        else $error("more than one channel strobed");
    a_idle_slots: assert property ((slot_d >= NCH) |=>
        ((o_contact_bias & ~$past(bias_ctrl_q)) == '0))
        else $error("strobe in idle slot");
    a_slot_step: assert property (s_slot_step |-> slot_q == $past(slot_q) + 1'b1)
        else $error("slot counter did not advance");
    a_slot_hold: assert property (!sb_rise |=> $stable(slot_q))
        else $error("slot changed without standby edge");
    a_sample_hold: assert property (!sb_fall |=> $stable(sample_q))
        else $error("sample changed outside strobe");
    a_sample_take: assert property (sb_fall && (slot_q == 0) |=> sample_q[0] == $past(live_q[0]))
        else $error("strobe did not latch comparator");
    a_flag_sticky: assert property (if_q && (|chan_req) |=> if_q)
        else $error("flag cleared while request active");
    a_irq_follow: assert property ((|chan_req) && en_q && !wr_irq |=> ##[0:1] o_irq)
        else $error("mismatch did not raise interrupt");
    a_perm_bias: assert property (bias_ctrl_q[1] |=> o_contact_bias[1])
        else $error("permanent bias not driven");

    // Bias only moves on a slot step or a control write
    a_bias_stand: assert property (!sb_rise && $stable(bias_ctrl_q) && !$past(i_reset)
        |=> $stable(o_contact_bias))
        else $error("bias changed inside a slot");
    a_slot_wrap: assert property (s_last_slot |=> (slot_q == '0))
        else $error("slot counter did not wrap");
    a_sample_any: assert property (s_mid_strobe |=>
        (((sample_q ^ $past(live_q)) & $past(strobe_sel)) == '0))
        else $error("sample bit differs from comparator");
    a_live_follow: assert property ((cmp2_q == cmp3_q) |=> (live_q == $past(cmp3_q)))
        else $error("live status missed settled comparator");
    a_flag_set: assert property ((|chan_req) |=> if_q)
        else $error("request did not set flag");
    a_flag_clear: assert property (!(|chan_req) && wr_irq
        && !i_bus.wdata[`CMS_IRQ_IF_BIT] |=> !if_q)
        else $error("flag not cleared by software");
    a_irq_mask: assert property (!en_q && !wr_irq |=> !o_irq)
        else $error("masked interrupt reached output");
    a_cmp_write: assert property (wr_cmp |=> (cmp_val_q == $past(i_bus.wdata[NCH-1:0])))
        else $error("compare value not written");
endmodule // cms_monitor

// file: tb/cms_switch_model.sv
/*
 * Switches to ground with series resistors behind the seven contact pins.
 * Assumes contact current flows only while the monitor biases the pin.
 */
module cms_switch_model (
    input wire logic [6:0] i_bias,
    input wire logic [6:0] i_closed,
    output logic [6:0] o_comp
);
    timeunit 1ns;
    timeprecision 1ns;
    // Current above threshold only on a biased, closed contact
    assign o_comp = i_bias & i_closed;
endmodule // cms_switch_model

// file: tb/tb_contact_monitor_strober.sv
/*
 * Bench of the contact monitor: register access, strobe sequence, interrupt flag.
 * Assumes cms_monitor and cms_switch_model; standby clock is 20 CPU clocks.
 */
`include "cms_params.svh"
module tb_contact_monitor_strober;
    timeunit 1ns;
    timeprecision 1ns;
    import cms_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic sb = 1'b0;
    logic [6:0] closed = 7'h00;
    logic [6:0] comp;
    logic [6:0] bias;
    cms_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] v;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int n[7];

    cms_monitor dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_standby_clock(sb),
        .i_contact_comp(comp), .i_bus(bus), .o_rdata(rdata), .o_contact_bias(bias),
        .o_irq(irq));
    cms_switch_model sw_u (.i_bias(bias), .i_closed(closed), .o_comp(comp));

    always #50 i_clk = ~i_clk;
    always begin
        repeat (10) @(negedge i_clk);
        sb = ~sb;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        bus = '{1'b1, 1'b0, a, d};
        @(negedge i_clk);
        bus = '0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        bus = '{1'b0, 1'b1, a, 8'h00};
        @(negedge i_clk);
        v = rdata;
        bus = '0;
        chk(v, e);
    endtask
    task automatic report_and_stop();
        $display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        rchk(`CMS_OFS_BIAS_CTRL, 8'h00);
        rchk(`CMS_OFS_IRQ_CTRL, 8'h00);
        rchk(`CMS_OFS_COMPARE, 8'h00);
        rchk(8'hE2, 8'h00);
        $display("Register reset test done");
        closed = 7'h08;
        wr(`CMS_OFS_BIAS_CTRL, 8'hFF);
        rchk(`CMS_OFS_BIAS_CTRL, 8'h7F);
        repeat (4) @(negedge i_clk);
        chk({1'b0, bias}, 8'h7F);
        rchk(`CMS_OFS_LIVE_STATUS, 8'h08);
        wr(`CMS_OFS_LIVE_STATUS, 8'h55);
        rchk(`CMS_OFS_LIVE_STATUS, 8'h08);
        wr(`CMS_OFS_BIAS_CTRL, 8'h00);
        $display("Permanent bias test done");
        closed = 7'h04;
        for (int k = 0; k < 11000 && bias !== 7'h01; k++) @(negedge i_clk);
        n = '{default: 0};
        repeat (10240) begin
            @(negedge i_clk);
            if ($countones(bias) > 1) chk({1'b0, bias}, 8'h00);
            for (int i = 0; i < 7; i++) n[i] += int'(bias[i]);
        end
        for (int i = 0; i < 7; i++) chk(8'(n[i]), 8'h14);
        $display("Strobe sequence test done");
        rchk(`CMS_OFS_IRQ_CTRL, 8'h40);
        chk({7'h00, irq}, 8'h00);
        wr(`CMS_OFS_IRQ_CTRL, 8'h80);
        rchk(`CMS_OFS_IRQ_CTRL, 8'hC0);
        chk({7'h00, irq}, 8'h01);
        wr(`CMS_OFS_COMPARE, 8'h04);
        wr(`CMS_OFS_IRQ_CTRL, 8'h80);
        rchk(`CMS_OFS_IRQ_CTRL, 8'h80);
        repeat (2) @(negedge i_clk);
        chk({7'h00, irq}, 8'h00);
        $display("Interrupt test done");
        report_and_stop();
    end
endmodule // tb_contact_monitor_strober
